/* File: hdl/cfg_mem_loader.v */
// configuration loader scanning a three-wire serial word memory
// Operation
// - probe memory after power-on or bus reset
// - use memory contents if valid, else defaults
// - high during acknowledge means invalid or absent
// - memory addressed as sixteen-bit words only
// - select, clock, shared data pin to memory
// - memory pins high impedance while in reset
// - regulated reset output low during reset input
// - fifo pins released to high impedance in reset
// - soft pull-down option pulls fifo pins low suspended
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_mem_loader #(
    parameter HALF_CYC = `SER_HALF_CYCLES
) (
    input  wire        sys_clk_i,
    input  wire        sys_rst_i,
    input  wire        dev_rst_n_i,
    input  wire        bus_reset_i,
    input  wire        suspend_i,
    input  wire        cfg_mem_shared_data_i,
    output reg         cfg_mem_select_o,
    output reg         cfg_mem_select_oe_o,
    output reg         cfg_mem_serial_clock_o,
    output reg         cfg_mem_serial_clock_oe_o,
    output reg         cfg_mem_shared_data_o,
    output reg         cfg_mem_shared_data_oe_o,
    output reg         regulated_reset_out_n_o,
    output reg         fifo_pins_oe_o,
    output reg         fifo_pull_low_o,
    output reg         cfg_done_o,
    output reg         cfg_from_mem_o,
    output reg  [15:0] cfg_power_o,
    output reg  [15:0] cfg_options_o,
    output reg  [15:0] cfg_vendor_o
);
    // ------------------------------------------------------------------------
    // state codes, one-hot
    // ------------------------------------------------------------------------
    localparam S_IDLE  = 7'b0000001;   // waiting for a scan request
    localparam S_CMD   = 7'b0000010;   // shifting start, opcode, address
    localparam S_ACK   = 7'b0000100;   // sampling the acknowledge
    localparam S_DATA  = 7'b0001000;   // shifting sixteen data bits in
    localparam S_GAP   = 7'b0010000;   // select low between words
    localparam S_APPLY = 7'b0100000;   // copy words or defaults out
    localparam S_DONE  = 7'b1000000;   // configured, holding

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    reg [1:0] rst_n_sync_reg;          // external reset pin
    reg [1:0] bus_rst_sync_reg;        // bus reset level
    reg [1:0] susp_sync_reg;           // suspend level
    reg [1:0] din_sync_reg;            // shared data pin
    always @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            rst_n_sync_reg   <= 2'b00;
            bus_rst_sync_reg <= 2'b00;
            susp_sync_reg    <= 2'b00;
            din_sync_reg     <= 2'b11;
        end
        else
        begin
            rst_n_sync_reg   <= {rst_n_sync_reg[0], dev_rst_n_i};
            bus_rst_sync_reg <= {bus_rst_sync_reg[0], bus_reset_i};
            susp_sync_reg    <= {susp_sync_reg[0], suspend_i};
            din_sync_reg     <= {din_sync_reg[0], cfg_mem_shared_data_i};
        end
    end
    wire in_reset = sys_rst_i | ~rst_n_sync_reg[1];   // held in device reset
    wire din      = din_sync_reg[1];                  // sampled memory output

    // ------------------------------------------------------------------------
    // serial clock divider: one-cycle enable per half period
    // ------------------------------------------------------------------------
    reg [7:0] div_reg;                 // half period counter
    reg       tick_reg;                // half period enable
    always @(posedge sys_clk_i)
    begin
        if (in_reset || div_reg == HALF_CYC[7:0] - 8'h01)
        begin
            div_reg  <= 8'h00;
            tick_reg <= ~in_reset;
        end
        else
        begin
            div_reg  <= div_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------------------
    reg [6:0]  state_reg;              // current state
    reg [9:0]  cmd_sr_reg;             // outgoing start, opcode, address
    reg [15:0] data_sr_reg;            // incoming word
    reg [4:0]  bit_cnt_reg;            // bits left in phase
    reg [1:0]  word_reg;               // word index being read
    reg        valid_reg;              // all acks seen so far
    reg        bus_rst_d_reg;          // previous bus reset level
    reg        sck_reg;                // serial clock level
    reg        we_reg;                 // store strobe
    reg [1:0]  apply_cnt_reg;          // readout step while applying
    wire [15:0] store_rdata;           // stored word readback
    wire start_scan = bus_rst_sync_reg[1] & ~bus_rst_d_reg;

    always @(posedge sys_clk_i)
    begin
        if (in_reset)
        begin
            // scan restarts after every reset release
            state_reg     <= S_CMD;
            cmd_sr_reg    <= {`RD_OPCODE, `CFG_ADDR_POWER, 1'b0};
            bit_cnt_reg   <= 5'd10;
            word_reg      <= 2'b00;
            valid_reg     <= 1'b1;
            sck_reg       <= 1'b0;
            we_reg        <= 1'b0;
            apply_cnt_reg <= 2'b00;
            bus_rst_d_reg <= 1'b0;
            cfg_mem_select_o         <= 1'b0;
            cfg_mem_shared_data_o    <= 1'b0;
            cfg_mem_shared_data_oe_o <= 1'b0;
            cfg_done_o    <= 1'b0;
        end
        else
        begin
            bus_rst_d_reg <= bus_rst_sync_reg[1];
            we_reg        <= 1'b0;
            if (start_scan)
            begin
                // a bus reset always forces a fresh scan
                state_reg   <= S_GAP;
                word_reg    <= 2'b00;
                valid_reg   <= 1'b1;
                bit_cnt_reg <= 5'd2;
                cfg_done_o  <= 1'b0;
                sck_reg     <= 1'b0;
                cfg_mem_select_o         <= 1'b0;
                cfg_mem_shared_data_o    <= 1'b0;
                cfg_mem_shared_data_oe_o <= 1'b0;
            end
            else
            begin
                case (state_reg)
                S_IDLE, S_DONE:
                    cfg_done_o <= (state_reg == S_DONE);   // held until next scan
                S_CMD, S_ACK, S_DATA:
                begin
                    if (tick_reg)
                    begin
                        sck_reg          <= ~sck_reg;
                        cfg_mem_select_o <= 1'b1;
                        if (!sck_reg && state_reg != S_ACK)
                        begin
                            // rising edge: memory takes a command bit or loader samples a data bit
                            bit_cnt_reg <= bit_cnt_reg - 5'd1;
                            if (state_reg == S_DATA)
                                data_sr_reg <= {data_sr_reg[14:0], din};
                            else
                                cfg_mem_shared_data_oe_o <= 1'b1;   // low lead-in is skipped
                        end
                        else if (sck_reg && state_reg == S_CMD)
                        begin
                            // falling edge: next command bit, line freed after the last
                            cfg_mem_shared_data_oe_o <= (bit_cnt_reg != 5'd0);
                            cfg_mem_shared_data_o    <= cmd_sr_reg[9];
                            cmd_sr_reg <= {cmd_sr_reg[8:0], 1'b0};
                            if (bit_cnt_reg == 5'd0)
                                state_reg <= S_ACK;
                        end
                        else if (sck_reg && state_reg == S_ACK)
                        begin
                            // memory pulls data low on a valid command
                            valid_reg   <= ~din;   // high: bad command or absent
                            state_reg   <= din ? S_APPLY : S_DATA;
                            bit_cnt_reg <= 5'd16;
                        end
                        else if (sck_reg && bit_cnt_reg == 5'd0)
                        begin
                            // last data bit in: store the word, drop select
                            we_reg           <= 1'b1;
                            state_reg        <= S_GAP;
                            bit_cnt_reg      <= 5'd1;
                            cfg_mem_select_o <= 1'b0;
                        end
                    end
                end
                S_GAP:
                begin
                    // select low for three half periods between words
                    sck_reg          <= 1'b0;
                    cfg_mem_select_o <= 1'b0;
                    if (tick_reg)
                    begin
                        bit_cnt_reg <= (bit_cnt_reg == 5'd0) ? 5'd10 : 5'd0;
                        cmd_sr_reg  <= {`RD_OPCODE, 4'h0, word_reg, 1'b0};
                        if (bit_cnt_reg == 5'd0)
                            state_reg <= S_CMD;
                        else if (bit_cnt_reg == 5'd1 && word_reg == 2'b11)
                            state_reg <= S_APPLY;
                        else if (bit_cnt_reg == 5'd1)
                            word_reg <= word_reg + 2'b01;
                    end
                end
                S_APPLY:
                begin
                    // walk the store once, then hold
                    apply_cnt_reg <= apply_cnt_reg + 2'b01;
                    if (apply_cnt_reg == 2'b11)
                        state_reg <= S_DONE;
                end
                default:
                begin
                    state_reg <= S_IDLE;
                end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // word store and configuration outputs
    // ------------------------------------------------------------------------
    cfg_word_store #(
        .DEPTH (`NUM_WORDS),
        .AW    (2),
        .WIDTH (`WORD_BITS)
    ) u_store (
        .sys_clk_i (sys_clk_i),
        .we_i      (we_reg),
        .waddr_i   (word_reg),
        .wdata_i   (data_sr_reg),
        .raddr_i   (~apply_cnt_reg),
        .rdata_o   (store_rdata)
    );

    reg [1:0] apply_d_reg;             // address of word now on readback
    reg       apply_v_reg;             // readback valid
    reg       mem_ok_reg;              // every ack seen and check word matched
    always @(posedge sys_clk_i)
    begin
        if (in_reset)
        begin
            apply_d_reg    <= 2'b00;
            apply_v_reg    <= 1'b0;
            mem_ok_reg     <= 1'b0;
            cfg_from_mem_o <= 1'b0;
            cfg_power_o    <= `DEF_POWER;
            cfg_options_o  <= `DEF_OPTIONS;
            cfg_vendor_o   <= `DEF_VENDOR;
        end
        else
        begin
            apply_d_reg    <= ~apply_cnt_reg;
            apply_v_reg    <= (state_reg == S_APPLY);
            cfg_from_mem_o <= mem_ok_reg && state_reg == S_DONE && !start_scan;
            if (apply_v_reg)
            begin
                // check word read first; memory words only when it matched
                case (apply_d_reg)
                2'd0: cfg_power_o   <= mem_ok_reg ? store_rdata : `DEF_POWER;
                2'd1: cfg_options_o <= mem_ok_reg ? store_rdata : `DEF_OPTIONS;
                2'd2: cfg_vendor_o  <= mem_ok_reg ? store_rdata : `DEF_VENDOR;
                default: mem_ok_reg <= valid_reg && store_rdata == `CHECK_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // pin enables and reset output
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_i)
    begin
        if (in_reset)
        begin
            cfg_mem_select_oe_o       <= 1'b0;   // release to other master
            cfg_mem_serial_clock_oe_o <= 1'b0;
            cfg_mem_serial_clock_o    <= 1'b0;
            regulated_reset_out_n_o   <= 1'b0;
            fifo_pins_oe_o            <= 1'b0;
            fifo_pull_low_o           <= 1'b0;
        end
        else
        begin
            cfg_mem_select_oe_o       <= 1'b1;
            cfg_mem_serial_clock_oe_o <= 1'b1;
            cfg_mem_serial_clock_o    <= sck_reg;   // 1 MHz clock
            regulated_reset_out_n_o   <= 1'b1;
            fifo_pins_oe_o            <= cfg_done_o;
            // soft pull-down during suspend when option bit set
            fifo_pull_low_o <= susp_sync_reg[1] & cfg_options_o[`OPT_SOFT_PULLDOWN];
        end
    end
endmodule

/* File: hdl/cfg_loader_consts.vh */
// constants for the serial configuration memory loader
`ifndef CFG_LOADER_CONSTS_VH
`define CFG_LOADER_CONSTS_VH

// ----------------------------------------------------------------------------
// serial clock timing
// ----------------------------------------------------------------------------
`define SYS_CLK_MHZ        125
`define SER_CLK_KHZ        1000
// system cycles per serial clock half period, rounded down
`define SER_HALF_CYCLES    ((`SYS_CLK_MHZ * 1000) / (`SER_CLK_KHZ * 2))

// ----------------------------------------------------------------------------
// read framing
// ----------------------------------------------------------------------------
`define RD_OPCODE          3'b110
`define ADDR_BITS          6
`define WORD_BITS          16
`define NUM_WORDS          4
`define CHECK_WORD         16'ha55a

// ----------------------------------------------------------------------------
// configuration word layout and defaults
// ----------------------------------------------------------------------------
`define CFG_ADDR_POWER     6'h00
`define CFG_ADDR_OPTIONS   6'h01
`define CFG_ADDR_VENDOR    6'h02
`define CFG_ADDR_CHECK     6'h03
`define OPT_SOFT_PULLDOWN  0
`define DEF_POWER          16'h0032
`define DEF_OPTIONS        16'h0000
`define DEF_VENDOR         16'h1234

`endif

/* File: hdl/cfg_word_store.v */
// small register memory holding the loaded configuration words
`timescale 1ns/1ps
module cfg_word_store #(
    parameter DEPTH  = 4,
    parameter AW     = 2,
    parameter WIDTH  = 16
) (
    input  wire             sys_clk_i,
    input  wire             we_i,
    input  wire [AW-1:0]    waddr_i,
    input  wire [WIDTH-1:0] wdata_i,
    input  wire [AW-1:0]    raddr_i,
    output reg  [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];   // word storage

    // ------------------------------------------------------------------------
    // write port and registered read
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_i)
    begin
        if (we_i)
        begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule

/* File: tb/cfg_mem_loader_assertions.sv */
// port checker for the configuration memory loader
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_mem_loader_checker #(
    parameter HALF_CYC = 4
) (
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        dev_rst_n_i,
    input wire logic        suspend_i,
    input wire logic        cfg_mem_select_o,
    input wire logic        cfg_mem_select_oe_o,
    input wire logic        cfg_mem_serial_clock_o,
    input wire logic        cfg_mem_serial_clock_oe_o,
    input wire logic        cfg_mem_shared_data_oe_o,
    input wire logic        regulated_reset_out_n_o,
    input wire logic        fifo_pins_oe_o,
    input wire logic        fifo_pull_low_o,
    input wire logic        cfg_done_o,
    input wire logic        cfg_from_mem_o,
    input wire logic [15:0] cfg_power_o,
    input wire logic [15:0] cfg_options_o,
    input wire logic [15:0] cfg_vendor_o
);
    // ------------------------------------------------------------------
    // helper: cycles the serial clock has held its level
    // ------------------------------------------------------------------
    logic [7:0] hold_reg;     // saturates so idle gaps never look too short
    logic       sck_last_reg; // serial clock one cycle back
    always @(posedge sys_clk_i)
    begin
        sck_last_reg <= cfg_mem_serial_clock_o;
        if (sys_rst_i)
            hold_reg <= 8'hff;
        else if (cfg_mem_serial_clock_o != sck_last_reg)
            hold_reg <= 8'h00;
        else if (hold_reg != 8'hff)
            hold_reg <= hold_reg + 8'h01;
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_pin_low; !dev_rst_n_i [*4]; endsequence
    sequence s_susp_on; suspend_i && cfg_done_o && cfg_options_o[0] [*4]; endsequence
    sequence s_susp_off; !suspend_i [*4]; endsequence
    property p_pins_off_rst;
        disable iff (1'b0) sys_rst_i |=> !cfg_mem_select_oe_o && !cfg_mem_serial_clock_oe_o
            && !cfg_mem_shared_data_oe_o;
    endproperty
    property p_pins_off_pin;
        s_pin_low |=> !cfg_mem_select_oe_o && !cfg_mem_serial_clock_oe_o
            && !cfg_mem_shared_data_oe_o && !regulated_reset_out_n_o;
    endproperty
    property p_regulated_reset_out_n_rst;
        disable iff (1'b0) sys_rst_i |=> !regulated_reset_out_n_o && !fifo_pins_oe_o;
    endproperty
    property p_fifo_pin; s_pin_low |=> !fifo_pins_oe_o; endproperty
    property p_data_in_frame;
        cfg_mem_shared_data_oe_o |-> cfg_mem_select_o && cfg_mem_select_oe_o;
    endproperty
    property p_src_done; cfg_from_mem_o |-> cfg_done_o; endproperty
    property p_defaults;
        cfg_done_o && !cfg_from_mem_o |-> cfg_power_o == `DEF_POWER
            && cfg_options_o == `DEF_OPTIONS && cfg_vendor_o == `DEF_VENDOR;
    endproperty
    property p_hold_cfg;
        cfg_done_o && $past(cfg_done_o) |-> $stable(cfg_power_o) && $stable(cfg_options_o)
            && $stable(cfg_vendor_o) && $stable(cfg_from_mem_o);
    endproperty
    property p_sck_rate;
        $changed(cfg_mem_serial_clock_o) && cfg_mem_serial_clock_oe_o
            && $past(cfg_mem_serial_clock_oe_o) |-> hold_reg >= HALF_CYC - 1;
    endproperty
    property p_pull_opt; fifo_pull_low_o |-> cfg_options_o[`OPT_SOFT_PULLDOWN]; endproperty
    property p_pull_on; s_susp_on |=> fifo_pull_low_o; endproperty
    property p_pull_off; s_susp_off |=> !fifo_pull_low_o; endproperty
    a_pins_off_rst: assert property (p_pins_off_rst)
        else $error("memory pins driven during reset");
    a_pins_off_pin: assert property (p_pins_off_pin)
        else $error("memory pins or reset out active while reset pin low");
    a_regulated_reset_out_n_rst: assert property (p_regulated_reset_out_n_rst)
        else $error("reset out or fifo drive active during reset");
    a_fifo_pin: assert property (p_fifo_pin)
        else $error("fifo pins driven while reset pin low");
    a_data_in_frame: assert property (p_data_in_frame)
        else $error("data pin driven outside a selected frame");
    a_src_done: assert property (p_src_done)
        else $error("memory source flagged before done");
    a_defaults: assert property (p_defaults)
        else $error("fallback configuration differs from defaults");
    a_hold_cfg: assert property (p_hold_cfg)
        else $error("configuration changed while done");
    a_sck_rate: assert property (p_sck_rate)
        else $error("serial clock half period too short");
    a_pull_opt: assert property (p_pull_opt)
        else $error("pull-down without option bit");
    a_pull_on: assert property (p_pull_on)
        else $error("pull-down missing in suspend");
    a_pull_off: assert property (p_pull_off)
        else $error("pull-down outside suspend");
endmodule
bind cfg_mem_loader cfg_mem_loader_checker #(.HALF_CYC(HALF_CYC)) i_cfg_mem_loader_checker (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .dev_rst_n_i(dev_rst_n_i),
    .suspend_i(suspend_i), .cfg_mem_select_o(cfg_mem_select_o),
    .cfg_mem_select_oe_o(cfg_mem_select_oe_o), .cfg_mem_serial_clock_o(cfg_mem_serial_clock_o),
    .cfg_mem_serial_clock_oe_o(cfg_mem_serial_clock_oe_o),
    .cfg_mem_shared_data_oe_o(cfg_mem_shared_data_oe_o),
    .regulated_reset_out_n_o(regulated_reset_out_n_o), .fifo_pins_oe_o(fifo_pins_oe_o),
    .fifo_pull_low_o(fifo_pull_low_o), .cfg_done_o(cfg_done_o),
    .cfg_from_mem_o(cfg_from_mem_o), .cfg_power_o(cfg_power_o),
    .cfg_options_o(cfg_options_o), .cfg_vendor_o(cfg_vendor_o));

/* File: tb/cfg_mem_model.sv */
// behavioural three-wire serial word memory at the loader's far side
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_mem_model (
    input  wire logic sel_i,
    input  wire logic sck_i,
    input  wire logic din_i,
    input  wire logic absent_i,
    output logic      dout_o,
    output logic      dout_oe_o
);
    logic [15:0] mem [0:63];   // sixteen-bit words only
    logic [8:0]  cmd_reg;      // start, opcode and address as shifted in
    logic [15:0] out_reg;      // word being shifted out
    int          bit_cnt = 0;  // command bits taken in this frame
    int          bad_cmd = 0;  // frames whose leading bits were not a read
    logic [5:0]  addr_log [$]; // addresses read, in order
    initial dout_oe_o = 1'b0;
    // deselect ends the frame and frees the data line to its pull-up
    always @(negedge sel_i)
    begin
        bit_cnt = 0;
        dout_oe_o = 1'b0;
    end
    // command bits on rising clock; zeros before the start bit are idle, any rate
    always @(posedge sck_i)
    begin
        if (sel_i === 1'b1 && bit_cnt < 9 && (bit_cnt > 0 || din_i === 1'b1))
        begin
            cmd_reg = {cmd_reg[7:0], din_i};
            bit_cnt++;
            if (bit_cnt == 9)
            begin
                if (cmd_reg[8:6] !== `RD_OPCODE)
                    bad_cmd++;
                addr_log.push_back(cmd_reg[5:0]);
                out_reg = mem[cmd_reg[5:0]];
                dout_o = 1'b0;           // acknowledge by pulling low
                dout_oe_o = !absent_i;   // a missing part leaves the pull-up
            end
        end
    end
    // first fall keeps the acknowledge low; later falls move data, msb first
    always @(negedge sck_i)
    begin
        if (sel_i === 1'b1 && bit_cnt == 10)
        begin
            dout_o = out_reg[15];
            out_reg = {out_reg[14:0], 1'b1};
        end
        if (sel_i === 1'b1 && bit_cnt == 9 && dout_oe_o)
            bit_cnt = 10;
    end
endmodule

/* File: tb/cfg_mem_loader_test.sv */
// self-checking bench for the configuration memory loader
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"
module cfg_mem_loader_test;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        sys_clk_i, sys_rst_i, dev_rst_n_i, bus_reset_i, suspend_i;
    logic        sel, sel_oe, sck, sck_oe, dout, dout_oe, mem_d, mem_oe;
    logic        rst_out_n, fifo_oe, pull_low, done, from_mem;
    logic [15:0] power, options, vendor;
    logic        mcu_sel, mcu_sck, mcu_d, absent; // outside controller and absent part
    logic [31:0] seed;
    int          fail_count, check_count, cycles;
    // device outranks memory output; data line has a pull-up
    wire sel_w  = sel_oe ? sel : mcu_sel;
    wire sck_w  = sck_oe ? sck : mcu_sck;
    wire data_w = dout_oe ? dout : (mem_oe ? mem_d : (dev_rst_n_i ? 1'b1 : mcu_d));
    cfg_mem_loader #(.HALF_CYC(4)) i_cfg_mem_loader (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .dev_rst_n_i(dev_rst_n_i),
        .bus_reset_i(bus_reset_i), .suspend_i(suspend_i), .cfg_mem_shared_data_i(data_w),
        .cfg_mem_select_o(sel), .cfg_mem_select_oe_o(sel_oe),
        .cfg_mem_serial_clock_o(sck), .cfg_mem_serial_clock_oe_o(sck_oe),
        .cfg_mem_shared_data_o(dout), .cfg_mem_shared_data_oe_o(dout_oe),
        .regulated_reset_out_n_o(rst_out_n), .fifo_pins_oe_o(fifo_oe),
        .fifo_pull_low_o(pull_low), .cfg_done_o(done), .cfg_from_mem_o(from_mem),
        .cfg_power_o(power), .cfg_options_o(options), .cfg_vendor_o(vendor));
    cfg_mem_model i_eeprom (.sel_i(sel_w), .sck_i(sck_w), .din_i(data_w),
        .absent_i(absent), .dout_o(mem_d), .dout_oe_o(mem_oe));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one scan: trig 0 power-on reset, 1 bus reset, 2 reset pin with shared memory
    task automatic scan(input int trig, input bit gone, input bit valid);
        logic [15:0] e_pow, e_opt, e_ven;
        bit          use_mem;
        for (int i = 0; i < 3; i++)
            i_eeprom.mem[i] = 16'(rnd());
        i_eeprom.mem[1][0] = (trig != 2);
        i_eeprom.mem[3] = valid ? `CHECK_WORD : ~`CHECK_WORD;
        if (trig == 2)
            i_eeprom.mem[0] = 16'h0000; // self-powered descriptor
        absent <= gone;
        sys_rst_i <= (trig == 0);
        bus_reset_i <= (trig == 1);
        dev_rst_n_i <= (trig != 2);
        repeat (12)
        begin
            @(posedge sys_clk_i);
            {mcu_sel, mcu_sck, mcu_d} <= (trig == 2) ? 3'(rnd()) : 3'b000;
        end
        @(negedge sys_clk_i);
        if (trig != 1)
        begin
            chk(16'(sel_oe | sck_oe | dout_oe), 16'h0, "memory pins driven");
            chk(16'(rst_out_n), 16'h0, "reset out");
            chk(16'(fifo_oe), 16'h0, "fifo pins driven");
        end
        @(posedge sys_clk_i);
        {sys_rst_i, bus_reset_i, dev_rst_n_i, mcu_sel, mcu_sck} <= 5'b00100;
        @(posedge sys_clk_i);
        i_eeprom.addr_log.delete();
        i_eeprom.bad_cmd = 0;
        // a full scan takes under 1000 cycles; the wait also shows the result holds
        repeat (1500) @(posedge sys_clk_i);
        use_mem = !gone && valid;
        e_pow = use_mem ? i_eeprom.mem[0] : `DEF_POWER;
        e_opt = use_mem ? i_eeprom.mem[1] : `DEF_OPTIONS;
        e_ven = use_mem ? i_eeprom.mem[2] : `DEF_VENDOR;
        @(negedge sys_clk_i);
        chk(16'(done), 16'h1, "done");
        chk(16'(from_mem), 16'(use_mem), "source");
        chk(power, e_pow, "power word");
        chk(options, e_opt, "option word");
        chk(vendor, e_ven, "vendor word");
        chk(16'(fifo_oe), 16'h1, "fifo pins after config");
        chk(16'(i_eeprom.addr_log.size()), gone ? 16'h1 : 16'h4, "read count");
        foreach (i_eeprom.addr_log[i])
            chk(16'(i_eeprom.addr_log[i]), 16'(i), "word address");
        chk(16'(i_eeprom.bad_cmd), 16'h0, "read framing");
        @(posedge sys_clk_i);
        suspend_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk(16'(pull_low), 16'(e_opt[0]), "suspend pull-down");
        @(posedge sys_clk_i);
        suspend_i <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        {sys_rst_i, dev_rst_n_i, bus_reset_i, suspend_i} = 4'b1100;
        {mcu_sel, mcu_sck, mcu_d, absent} = 4'b0000;
        seed = 32'h31d8b0b8;
        scan(0, 1'b0, 1'b1);
        scan(1, 1'b0, 1'b0);
        scan(2, 1'b0, 1'b1);
        scan(1, 1'b1, 1'b1);
        scan(0, 1'b0, 1'b1);
        final_report();
    end
endmodule
